//--- rmbc_pkg.sv
package rmbc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int                 RMBC_AW      = 10;
  localparam logic [RMBC_AW-1:0] RMBC_A_CTRL  = 10'h000;
  localparam logic [RMBC_AW-1:0] RMBC_A_STAT  = 10'h004;
  localparam logic [RMBC_AW-1:0] RMBC_A_DSTAT = 10'h008;
  localparam logic [RMBC_AW-1:0] RMBC_A_UCNT  = 10'h00C;
  localparam logic [RMBC_AW-1:0] RMBC_A_SPTR  = 10'h010;
  localparam logic [RMBC_AW-1:0] RMBC_A_DEFV  = 10'h014;
  localparam logic [RMBC_AW-1:0] RMBC_A_MZS   = 10'h018;
  localparam logic [RMBC_AW-1:0] RMBC_A_EMB   = 10'h01C;
  localparam logic [RMBC_AW-1:0] RMBC_A_LIEND = 10'h020;
  localparam logic [RMBC_AW-1:0] RMBC_A_ML0   = 10'h024;
  localparam logic [RMBC_AW-1:0] RMBC_A_ML1   = 10'h028;
  localparam logic [RMBC_AW-1:0] RMBC_A_LOST  = 10'h02C;
  localparam logic [RMBC_AW-1:0] RMBC_A_RXST  = 10'h030;
  localparam logic [1:0]         RMBC_A_PPI   = 2'b01;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RMBC_C_GO   = 0;
  localparam int RMBC_C_KIND = 1;
  localparam int RMBC_C_FLD  = 2;
  localparam int RMBC_C_CCLR = 6;
  localparam int RMBC_C_GRST = 7;
  localparam int RMBC_C_DCLR = 8;
  localparam int RMBC_S_BUSY = 0;
  localparam int RMBC_S_ERR  = 1;
  localparam int RMBC_S_WP   = 2;
  localparam int RMBC_S_ILL  = 3;
  localparam int RMBC_S_POS  = 4;

  // ----------------------------------------------------------------
  // Reset values and field constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  RMBC_DSTAT_RST = 8'h00;
  localparam logic [31:0] RMBC_UCNT_RST  = 32'h0000_0000;
  localparam logic [3:0]  RMBC_POS_FIRST = 4'h1;
  localparam logic [3:0]  RMBC_GRP_LEN   = 4'h5;
  localparam logic [2:0]  RMBC_SET_BLKS  = 3'h5;
  localparam logic [2:0]  RMBC_DEF_THR   = 3'h3;
  localparam logic [4:0]  RMBC_SET_FIRST = 5'h02;
  localparam logic [4:0]  RMBC_SET_LAST  = 5'h1C;
  localparam logic [7:0]  RMBC_FMT_PTR   = 8'h02;
  localparam logic [7:0]  RMBC_FMT_WRK   = 8'h03;
  localparam logic [7:0]  RMBC_PTR_DSTAT = 8'h10;
  localparam logic [10:0] RMBC_LAST_IDX  = 11'h7FF;
  localparam logic [10:0] RMBC_PPI_LO    = 11'h016;
  localparam logic [10:0] RMBC_PPI_HI    = 11'h055;
  localparam logic [10:0] RMBC_GRP_IDX   = 11'h080;

  typedef enum logic [1:0]
  {
    RMBC_G_IDLE  = 2'b00,
    RMBC_G_FETCH = 2'b01,
    RMBC_G_FORM  = 2'b10,
    RMBC_G_SEND  = 2'b11
  } rmbc_gen_type;

  // Pre-pit copy byte class: 0 zero filler, 1 data, 2 field id
  function automatic logic [1:0] rmbc_ppi_class(input logic [5:0] o);
    logic [2:0] b;
    b = o[2:0];
    if (o > 6'd32)
      rmbc_ppi_class = 2'd0;
    else if (b == 3'd0)
      rmbc_ppi_class = 2'd2;
    else if (o[5:3] == 3'd0)
      rmbc_ppi_class = (b < 3'd7) ? 2'd1 : 2'd0;
    else if (o[5:3] == 3'd1)
      rmbc_ppi_class = (b > 3'd2 && b < 3'd6) ? 2'd1 : 2'd0;
    else
      rmbc_ppi_class = (b < 3'd7 && o[5:3] != 3'd4) ? 2'd1 : 2'd0;
  endfunction

  function automatic logic rmbc_dstat_legal(input logic [7:0] s);
    case (s)
      8'h00, 8'h11, 8'h12, 8'h13, 8'h80, 8'h92, 8'h93:
        rmbc_dstat_legal = 1'b1;
      default:
        rmbc_dstat_legal = 1'b0;
    endcase
  endfunction

endpackage

//--- rmbc_byte_mem.sv
`timescale 1ns/100ps
module rmbc_byte_mem
(
  // Clock
  input  wire logic       mclk,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [5:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Read port
  input  wire logic [5:0] rd_addr,
  output logic      [7:0] rd_data_r
);
  logic [7:0] mem [0:63];

  always_ff @(posedge mclk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data_r <= mem[rd_addr];
  end
endmodule

//--- rmbc_set_defect.sv
`timescale 1ns/100ps
module rmbc_set_defect
  import rmbc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        clr,
  // Block results
  input  wire logic        blk_valid,
  input  wire logic        blk_fail,
  input  wire logic [4:0]  blk_set,
  // Packed defect bits
  output logic      [31:0] defect_vec_r
);
  logic [4:0] cur_set_r;
  logic [2:0] nblk_r;
  logic [2:0] nfail_r;
  logic       fresh;
  logic [2:0] nblk_nxt;
  logic [2:0] nfail_nxt;

  // A new set index, or a full set, starts a new tally
  always_comb
  begin
    fresh     = (blk_set != cur_set_r) || (nblk_r == RMBC_SET_BLKS);
    nblk_nxt  = fresh ? 3'd1 : nblk_r + 3'd1;
    nfail_nxt = (fresh ? 3'd0 : nfail_r) + {2'b00, blk_fail};
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_set_r <= 5'h00;
      nblk_r    <= 3'd0;
      nfail_r   <= 3'd0;
    end
    else if (clr)
    begin
      nblk_r  <= 3'd0;
      nfail_r <= 3'd0;
    end
    else if (blk_valid)
    begin
      cur_set_r <= blk_set;
      nblk_r    <= nblk_nxt;
      nfail_r   <= nfail_nxt;
    end
  end

  // Set n sits at bit n-1; bit 0 and bits 28..31 never set
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      defect_vec_r <= 32'h0000_0000;
    else if (clr)
      defect_vec_r <= 32'h0000_0000;
    else if (blk_valid && nblk_nxt == RMBC_SET_BLKS &&
             blk_set >= RMBC_SET_FIRST && blk_set <= RMBC_SET_LAST)
      defect_vec_r[blk_set - 5'd1] <= (nfail_nxt >= RMBC_DEF_THR);
  end
endmodule

//--- rmbc_top.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
// Notes on behaviour
// - Pre-pit copy with ids 01..05, zero fillers
// - Byte 128: low nibble length, high position
// - Group length 5, positions run 1 to 5
// - All blocks of a group share length
// - Rewrite counter starts 0, plus one per rewrite
// - Counter carries over into next segment
// - Set pointer bytes 4-7, bytes 8-15 zero
// - At most two failing blocks: usable
// - Three or more failing blocks: defective
// - Defect bits packed sets 2..28, rest zero
// - Pointer fields 2 to 14 all zero
// - Working field 0 zone and address bytes
// - Working format bytes read 0003
// - Status MSB or hole means protected
// - Codes 00,11,12,13 blank/format/complete/middle
// - Codes 80,92,93 protected variants
// - Only the seven codes may be written
// - Byte 3 zero, disc identifier ignored
// - Five segments, 28 sets, five blocks each
// - Pointer format bytes read 0002
module rmbc_top
  import rmbc_pkg::*;
(
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [rmbc_pkg::RMBC_AW-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic      [31:0]                 prdata,
  output logic                             pslverr,
  // Cartridge write-inhibit hole
  input  wire logic                        wp_hole_pin,
  // Field byte stream out
  output logic      [7:0]                  tx_data,
  output logic                             tx_valid,
  output logic                             tx_last,
  input  wire logic                        tx_ready,
  // Field byte stream back
  input  wire logic                        rx_valid,
  input  wire logic                        rx_sof,
  input  wire logic [7:0]                  rx_data,
  // Per-block error detection result
  input  wire logic                        edc_valid,
  input  wire logic                        edc_fail,
  input  wire logic [4:0]                  edc_set,
  // Status
  output logic                             wprot,
  output logic                             chk_err
);
  import rmbc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic         kind_r;
  logic [3:0]   fld_r;
  logic [7:0]   dstat_r;
  logic [31:0]  ucnt_r;
  logic [31:0]  sptr_r;
  logic [31:0]  mzs_r;
  logic [4:0]   emb_r;
  logic [31:0]  addr_r [0:3];
  logic [3:0]   pos_r;
  logic         ill_r;
  logic [7:0]   rx_stat_r;
  logic [10:0]  rx_idx_r;
  logic         hole_s1_r;
  logic         hole_s2_r;
  rmbc_gen_type gst_r;
  logic [10:0]  gidx_r;
  logic         wr_acc;
  logic         acc;
  logic         go;
  logic         err_clr;
  logic         mapped;
  logic [31:0]  rd_word;
  logic [7:0]   mem_rd;
  logic [31:0]  defect_vec;
  logic [8:0]   gfix;
  logic [7:0]   gvar;
  logic [8:0]   cfix;
  logic [10:0]  cidx;
  logic         cerr;
  logic         gdone;

  // ----------------------------------------------------------------
  // Byte helpers
  // ----------------------------------------------------------------
  // Multi-byte numbers except the defect bits go out most significant byte first
  function automatic logic [7:0] wbyte(input logic [31:0] w,
                                       input logic [1:0]  i);
    wbyte = w[{~i, 3'b000} +: 8];
  endfunction

  // Returns {fixed, value}; non-fixed bytes carry data
  function automatic logic [8:0] fixed_byte(input logic        k,
                                            input logic [3:0]  f,
                                            input logic [10:0] i);
    logic [5:0] po;
    po = 6'(i - RMBC_PPI_LO);
    fixed_byte = {1'b1, 8'h00};
    if (k && f != 4'd0)
      fixed_byte = {1'b0, 8'h00};
    else if (f == 4'd0)
    begin
      if (i == 11'd1)
        fixed_byte = {1'b1, k ? RMBC_FMT_WRK : RMBC_FMT_PTR};
      else if (i == 11'd2)
        fixed_byte = k ? {1'b0, 8'h00} : {1'b1, RMBC_PTR_DSTAT};
      else if (i >= 11'd4 && i <= 11'd21)
        fixed_byte = {1'b0, 8'h00};
      else if (i >= RMBC_PPI_LO && i <= RMBC_PPI_HI)
      begin
        case (rmbc_ppi_class(po))
          2'd1:    fixed_byte = {1'b0, 8'h00};
          2'd2:    fixed_byte = {1'b1, 5'd0, 3'(po[5:3] + 3'd1)};
          default: fixed_byte = {1'b1, 8'h00};
        endcase
      end
      else if (k && i >= 11'd86 && i <= 11'd107 && i != 11'd91)
        fixed_byte = {1'b0, 8'h00};
      else if (i == RMBC_GRP_IDX)
        fixed_byte = {1'b0, 8'h00};
    end
    else if (f == 4'd1 && (i < 11'd8 || (i >= 11'd16 && i <= 11'd19)))
      fixed_byte = {1'b0, 8'h00};
  endfunction

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer on the second access cycle
  // ----------------------------------------------------------------
  assign acc    = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign mapped = (paddr[9:8] == RMBC_A_PPI) || (paddr <= RMBC_A_RXST);
  assign go     = wr_acc && paddr == RMBC_A_CTRL && pwdata[RMBC_C_GO] &&
                  gst_r == RMBC_G_IDLE;
  assign err_clr = wr_acc && paddr == RMBC_A_STAT && pwdata[RMBC_S_ERR];

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (paddr)
      RMBC_A_CTRL:  rd_word = {27'd0, fld_r, kind_r};
      RMBC_A_STAT:  rd_word = {24'd0, pos_r, ill_r, wprot, chk_err,
                               gst_r != RMBC_G_IDLE};
      RMBC_A_DSTAT: rd_word = {24'd0, dstat_r};
      RMBC_A_UCNT:  rd_word = ucnt_r;
      RMBC_A_SPTR:  rd_word = sptr_r;
      RMBC_A_DEFV:  rd_word = defect_vec;
      RMBC_A_MZS:   rd_word = mzs_r;
      RMBC_A_EMB:   rd_word = {27'd0, emb_r};
      RMBC_A_LIEND: rd_word = addr_r[0];
      RMBC_A_ML0:   rd_word = addr_r[1];
      RMBC_A_ML1:   rd_word = addr_r[2];
      RMBC_A_LOST:  rd_word = addr_r[3];
      RMBC_A_RXST:  rd_word = {24'd0, rx_stat_r};
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      prdata  <= rd_word;
      pslverr <= psel && penable && !pready && (!mapped ||
                 (pwrite && paddr == RMBC_A_DSTAT &&
                  !rmbc_dstat_legal(pwdata[7:0])));
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      kind_r    <= 1'b0;
      fld_r     <= 4'h0;
      sptr_r    <= 32'h0000_0000;
      mzs_r     <= 32'h0000_0000;
      emb_r     <= 5'h00;
      addr_r[0] <= 32'h0000_0000;
      addr_r[1] <= 32'h0000_0000;
      addr_r[2] <= 32'h0000_0000;
      addr_r[3] <= 32'h0000_0000;
    end
    else if (wr_acc)
    begin
      case (paddr)
        RMBC_A_CTRL:
        begin
          if (gst_r == RMBC_G_IDLE)
          begin
            kind_r <= pwdata[RMBC_C_KIND];
            fld_r  <= pwdata[RMBC_C_FLD +: 4];
          end
        end
        RMBC_A_SPTR:  sptr_r    <= pwdata;
        RMBC_A_MZS:   mzs_r     <= pwdata;
        RMBC_A_EMB:   emb_r     <= pwdata[4:0];
        RMBC_A_LIEND: addr_r[0] <= pwdata;
        RMBC_A_ML0:   addr_r[1] <= pwdata;
        RMBC_A_ML1:   addr_r[2] <= pwdata;
        RMBC_A_LOST:  addr_r[3] <= pwdata;
        default:      kind_r    <= kind_r;
      endcase
    end
  end

  // Illegal codes are refused and the old one stays
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dstat_r <= RMBC_DSTAT_RST;
      ill_r   <= 1'b0;
    end
    else if (wr_acc && paddr == RMBC_A_DSTAT)
    begin
      if (rmbc_dstat_legal(pwdata[7:0]))
        dstat_r <= pwdata[7:0];
      ill_r <= !rmbc_dstat_legal(pwdata[7:0]);
    end
  end

  // Counter is never cleared on a segment change, only by software
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ucnt_r <= RMBC_UCNT_RST;
    else if (wr_acc && paddr == RMBC_A_CTRL && pwdata[RMBC_C_CCLR])
      ucnt_r <= RMBC_UCNT_RST;
    else if (gdone && !kind_r && fld_r == 4'd1)
      ucnt_r <= ucnt_r + 32'd1;
  end

  // Position steps 1..5 after each field 0 block
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pos_r <= RMBC_POS_FIRST;
    else if (wr_acc && paddr == RMBC_A_CTRL && pwdata[RMBC_C_GRST])
      pos_r <= RMBC_POS_FIRST;
    else if (gdone && fld_r == 4'd0)
      pos_r <= (pos_r == RMBC_GRP_LEN) ? RMBC_POS_FIRST : pos_r + 4'd1;
  end

  // ----------------------------------------------------------------
  // Write-protect: status MSB or the cartridge hole
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hole_s1_r <= 1'b0;
      hole_s2_r <= 1'b0;
      wprot     <= 1'b0;
    end
    else
    begin
      hole_s1_r <= wp_hole_pin;
      hole_s2_r <= hole_s1_r;
      wprot     <= dstat_r[7] || hole_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Field generator
  // ----------------------------------------------------------------
  // At least three cycles per byte: address, memory data into the byte, then send
  assign gfix  = fixed_byte(kind_r, fld_r, gidx_r);
  assign gdone = gst_r == RMBC_G_SEND && tx_ready && gidx_r == RMBC_LAST_IDX;

  always_comb
  begin
    gvar = 8'h00;
    if (fld_r == 4'd0)
    begin
      if (gidx_r == 11'd2)
        gvar = dstat_r;
      else if (gidx_r >= RMBC_PPI_LO && gidx_r <= RMBC_PPI_HI)
        gvar = mem_rd;
      else if (gidx_r == RMBC_GRP_IDX)
        gvar = {pos_r, RMBC_GRP_LEN};
      else if (gidx_r >= 11'd86 && gidx_r <= 11'd89)
        gvar = wbyte(mzs_r, gidx_r[1:0] - 2'd2);
      else if (gidx_r == 11'd90)
        gvar = {3'b000, emb_r};
      else if (gidx_r >= 11'd92 && gidx_r <= 11'd107)
        gvar = wbyte(addr_r[2'(4'(gidx_r[5:2]) - 4'd7)], gidx_r[1:0]);
    end
    else if (!kind_r && fld_r == 4'd1)
    begin
      if (gidx_r < 11'd4)
        gvar = wbyte(ucnt_r, gidx_r[1:0]);
      else if (gidx_r < 11'd8)
        gvar = wbyte(sptr_r, gidx_r[1:0]);
      else
        gvar = defect_vec[{gidx_r[1:0], 3'b000} +: 8];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gst_r    <= RMBC_G_IDLE;
      gidx_r   <= 11'd0;
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end
    else
    begin
      case (gst_r)
        RMBC_G_IDLE:
        begin
          gidx_r <= 11'd0;
          if (go)
            gst_r <= RMBC_G_FETCH;
        end
        RMBC_G_FETCH:
          gst_r <= RMBC_G_FORM;
        RMBC_G_FORM:
        begin
          tx_data  <= gfix[8] ? gfix[7:0] : gvar;
          tx_valid <= 1'b1;
          tx_last  <= gidx_r == RMBC_LAST_IDX;
          gst_r    <= RMBC_G_SEND;
        end
        RMBC_G_SEND:
        begin
          if (tx_ready)
          begin
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
            gidx_r   <= gidx_r + 11'd1;
            gst_r    <= (gidx_r == RMBC_LAST_IDX) ? RMBC_G_IDLE : RMBC_G_FETCH;
          end
        end
        default:
          gst_r <= RMBC_G_IDLE;
      endcase
    end
  end

  rmbc_byte_mem u_ppi
  (
    .mclk      (mclk),
    .wr_en     (wr_acc && paddr[9:8] == RMBC_A_PPI),
    .wr_addr   (paddr[7:2]),
    .wr_data   (pwdata[7:0]),
    .rd_addr   (6'(gidx_r - RMBC_PPI_LO)),
    .rd_data_r (mem_rd)
  );

  // ----------------------------------------------------------------
  // Readback checker
  // ----------------------------------------------------------------
  assign cidx = rx_sof ? 11'd0 : rx_idx_r;
  assign cfix = fixed_byte(kind_r, fld_r, cidx);

  always_comb
  begin
    cerr = cfix[8] && rx_data != cfix[7:0];
    if (kind_r && fld_r == 4'd0 && cidx == 11'd2)
      cerr = !rmbc_dstat_legal(rx_data);
    else if (fld_r == 4'd0 && cidx == RMBC_GRP_IDX)
      cerr = rx_data[3:0] != RMBC_GRP_LEN || rx_data[7:4] == 4'd0 ||
             rx_data[7:4] > RMBC_GRP_LEN;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_idx_r  <= 11'd0;
      rx_stat_r <= 8'h00;
    end
    else if (rx_valid)
    begin
      rx_idx_r <= cidx + 11'd1;
      if (cidx == 11'd2 && fld_r == 4'd0)
        rx_stat_r <= rx_data;
    end
  end

  // Sticky error: a new error wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      chk_err <= 1'b0;
    else if (rx_valid && cerr)
      chk_err <= 1'b1;
    else if (err_clr)
      chk_err <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Set defect tally
  // ----------------------------------------------------------------
  rmbc_set_defect u_defect
  (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .clr          (wr_acc && paddr == RMBC_A_CTRL && pwdata[RMBC_C_DCLR]),
    .blk_valid    (edc_valid),
    .blk_fail     (edc_fail),
    .blk_set      (edc_set),
    .defect_vec_r (defect_vec)
  );
endmodule

//--- rmbc_top_properties.sv
`timescale 1ns/100ps
module rmbc_top_properties
  import rmbc_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic       pready,
  input wire logic       pslverr,
  // Streams and status
  input wire logic       wp_hole_pin,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_last,
  input wire logic       tx_ready,
  input wire logic       wprot,
  input wire logic       chk_err
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  wire logic err_clr_w = psel && penable && pready && pwrite &&
                         paddr == RMBC_A_STAT && pwdata[RMBC_S_ERR];
  chk_apb_wait: assert property (s_setup |-> !pready ##1 pready)
    else $error("access did not end after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stayed high");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("stalled byte changed");
  chk_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid [*2])
    else $error("byte gap too short");
  chk_last_zero: assert property (tx_valid && tx_last |-> tx_data == 8'h00)
    else $error("final field byte not zero");
  chk_err_sticky: assert property (chk_err && !err_clr_w |=> chk_err)
    else $error("checker error dropped");
  chk_hole_prot: assert property (wp_hole_pin [*5] |=> wprot)
    else $error("hole did not protect");
endmodule

//--- rmbc_drive_model.sv
`timescale 1ns/100ps
module rmbc_drive_model
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Byte sink
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  input  wire logic        tx_last,
  output logic             tx_ready,
  // Readback source
  output logic             rx_valid,
  output logic             rx_sof,
  output logic      [7:0]  rx_data,
  // Control
  input  wire logic        slow,
  input  wire logic        replay,
  input  wire logic        bad_en,
  input  wire logic [10:0] bad_idx
);
  logic [7:0]  mem [2048];
  logic [10:0] wi;
  logic [11:0] ri;
  logic [1:0]  st;
  logic        play;
  int          fields;
  // Slow mode stalls three cycles out of four
  assign tx_ready = !slow || st == 2'd3;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      st     <= '0;
      wi     <= '0;
      fields <= 0;
    end
    else
    begin
      st <= st + 2'd1;
      if (tx_valid && tx_ready)
      begin
        mem[wi] <= tx_data;
        wi      <= tx_last ? 11'd0 : wi + 11'd1;
        if (tx_last)
          fields <= fields + 1;
      end
    end
  // Released data line shows the inverse so stale bytes never match
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      play     <= 1'b0;
      ri       <= '0;
      rx_valid <= 1'b0;
      rx_sof   <= 1'b0;
      rx_data  <= '0;
    end
    else if (play)
    begin
      rx_valid <= 1'b1;
      rx_sof   <= ri == 12'd0;
      rx_data  <= (bad_en && ri[10:0] == bad_idx) ? 8'h14 : mem[ri[10:0]];
      ri       <= ri + 12'd1;
      play     <= ri != 12'd2047;
    end
    else
    begin
      play     <= replay;
      ri       <= '0;
      rx_valid <= 1'b0;
      rx_sof   <= 1'b0;
      rx_data  <= ~rx_data;
    end
endmodule

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import rmbc_pkg::*;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, wp_hole_pin = 0;
  logic edc_valid = 0, edc_fail = 0, slow = 0, replay = 0, bad_en = 0, err;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0, rd;
  logic [4:0] edc_set = '0;
  logic [7:0] cs [7] = '{8'h00, 8'h11, 8'h12, 8'h13, 8'h80, 8'h92, 8'h93};
  wire logic pready, pslverr, tx_valid, tx_last, tx_ready, rx_valid, rx_sof, wprot, chk_err;
  wire logic [31:0] prdata;
  wire logic [7:0] tx_data, rx_data;
  int error_cnt = 0, checks = 0, cyc = 0, f0, nz;
  rmbc_top i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .wp_hole_pin(wp_hole_pin), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_data(rx_data), .edc_valid(edc_valid), .edc_fail(edc_fail), .edc_set(edc_set),
    .wprot(wprot), .chk_err(chk_err));
  rmbc_drive_model i_sink (.mclk(mclk), .rst_n(rst_n), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_sof(rx_sof), .rx_data(rx_data), .slow(slow), .replay(replay), .bad_en(bad_en),
    .bad_idx(11'd2));
  always #4 mclk = ~mclk;
  task end_sim;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  // Waits for the whole field and then for busy to drop
  task gen(input logic [31:0] c);
    f0 = i_sink.fields;
    apb(1, RMBC_A_CTRL, c);
    while (i_sink.fields == f0) @(posedge mclk);
    do apb(0, RMBC_A_STAT, 0); while (rd[RMBC_S_BUSY] !== 1'b0);
  endtask
  task edc(input logic [4:0] s, input int nf);
    for (int b = 0; b < 5; b++)
    begin
      edc_valid <= 1;
      edc_set <= s;
      edc_fail <= b < nf;
      @(posedge mclk);
    end
    edc_valid <= 0;
    @(posedge mclk);
  endtask
  function automatic logic [7:0] mb(int i);
    return i_sink.mem[i];
  endfunction
  function automatic logic [7:0] ppi_exp(int i);
    if (i % 8 == 0 && i <= 32)
      return 8'(i / 8 + 1);
    if ((i >= 1 && i <= 6) || (i >= 11 && i <= 13) || (i >= 17 && i <= 22) || (i >= 25 && i <= 30))
      return 8'(8'h40 + i);
    return 8'h00;
  endfunction
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    apb(0, RMBC_A_UCNT, 0);
    chk("ucnt", rd, 32'h0000_0000);
    for (int i = 0; i < 64; i++)
      apb(1, 10'h100 + 10'(4 * i), 32'(8'h40 + i));
    apb(1, RMBC_A_SPTR, 32'h0003_1234);
    apb(1, RMBC_A_MZS, 32'h0001_0203);
    apb(1, RMBC_A_EMB, 32'h0000_0016);
    apb(1, RMBC_A_LIEND, 32'h00FF_D1E0);
    gen(32'h0000_0001);
    chk("p0 fmt", {mb(0), mb(1)}, 32'h0000_0002);
    chk("p0 b3", mb(3), 8'h00);
    for (int i = 0; i < 64; i++)
      chk("ppi", mb(22 + i), ppi_exp(i));
    chk("p0 grp", mb(128), 8'h15);
    foreach (cs[i])
    begin
      apb(1, RMBC_A_DSTAT, 32'(cs[i]));
      chk("code err", err, 1'b0);
      apb(0, RMBC_A_DSTAT, 0);
      chk("code", rd, 32'(cs[i]));
      chk("wprot", wprot, cs[i][7]);
    end
    apb(1, RMBC_A_DSTAT, 32'h0000_0014);
    chk("bad code err", err, 1'b1);
    apb(0, RMBC_A_STAT, 0);
    chk("ill", rd[RMBC_S_ILL], 1'b1);
    apb(0, RMBC_A_DSTAT, 0);
    chk("kept", rd, 32'h0000_0093);
    apb(1, RMBC_A_DSTAT, 32'h0000_0012);
    wp_hole_pin <= 1;
    repeat (5) @(posedge mclk);
    chk("hole", wprot, 1'b1);
    wp_hole_pin <= 0;
    slow <= 1;
    gen(32'h0000_0003);
    slow <= 0;
    chk("w0 fmt", {mb(0), mb(1), mb(2), mb(3)}, 32'h0003_1200);
    chk("mzs", {mb(86), mb(87), mb(88), mb(89)}, 32'h0001_0203);
    chk("emb", {mb(90), mb(91)}, 32'h0000_1600);
    chk("liend", {mb(92), mb(93), mb(94), mb(95)}, 32'h00FF_D1E0);
    chk("w0 pad", mb(108), 8'h00);
    chk("w0 grp", mb(128), 8'h25);
    for (int p = 0; p < 2; p++)
    begin
      bad_en <= p[0];
      replay <= 1;
      @(posedge mclk) replay <= 0;
      repeat (2100) @(posedge mclk);
      chk("rx err", chk_err, p[0]);
    end
    apb(1, RMBC_A_STAT, 32'h0000_0002);
    chk("rx clr", chk_err, 1'b0);
    edc(5'd2, 2);
    edc(5'd3, 3);
    edc(5'd28, 3);
    edc(5'd1, 5);
    apb(0, RMBC_A_DEFV, 0);
    chk("defv", rd, 32'h0800_0004);
    gen(32'h0000_0005);
    chk("ucnt0", {mb(0), mb(1), mb(2), mb(3)}, 32'h0000_0000);
    chk("sptr", {mb(4), mb(5), mb(6), mb(7)}, 32'h0003_1234);
    chk("defb", {mb(19), mb(18), mb(17), mb(16)}, 32'h0800_0004);
    chk("f1 pad", {mb(8), mb(15), mb(20), mb(2047)}, 32'h0000_0000);
    gen(32'h0000_0005);
    chk("ucnt1", {mb(0), mb(1), mb(2), mb(3)}, 32'h0000_0001);
    gen(32'h0000_0009);
    nz = 0;
    for (int i = 0; i < 2048; i++)
      nz += mb(i) !== 8'h00;
    chk("f2 zero", nz, 0);
    apb(0, RMBC_A_STAT, 0);
    chk("pos", rd[7:4], 4'h3);
    end_sim();
  end
endmodule
bind rmbc_top rmbc_top_properties i_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .wp_hole_pin(wp_hole_pin), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_last(tx_last), .tx_ready(tx_ready), .wprot(wprot), .chk_err(chk_err));
